// [rtl/pwm_timer_pkg.sv]
package pwm_timer_pkg;
    // Data path widths and channel count
    localparam int CNT_W = 16;
    localparam int SKIP_W = 5;
    localparam int NUM_CH = 2;
    localparam int IRQ_W = 2;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LIMIT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNTER_START = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_SETUP = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_BUFFER_LOAD = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MATCH0 = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_MATCH1 = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;

    // Field positions
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_IE_BIT = 6;
    localparam int CTL_FLAG_BIT = 7;
    localparam int LOAD_PERMIT_BIT = 9;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_LOAD_BIT = 1;

    // Reset values
    localparam logic [CNT_W-1:0] LIMIT_RST = 16'hffff;
    localparam logic [CNT_W-1:0] START_RST = 16'h0000;
    localparam logic [CNT_W-1:0] MATCH_RST = 16'h0000;
    localparam logic [SKIP_W-1:0] SKIP_RST = 5'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
endpackage

// [rtl/pwm_match_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module pwm_match_channel (
    input wire logic clk_i,                                 // Module clock
    input wire logic srst_i,                                // Sync reset, high
    input wire logic wr_i,                                  // Write buffered match value
    input wire logic [pwm_timer_pkg::CNT_W-1:0] wdata_i,    // Merged write data
    input wire logic load_i,                                // Buffer to active transfer
    input wire logic [pwm_timer_pkg::CNT_W-1:0] cnt_i,      // Counter value
    output logic [pwm_timer_pkg::CNT_W-1:0] buf_o,          // Buffered value, read back
    output logic pwm_o                                      // High while counter below match
);
    import pwm_timer_pkg::*;

    logic [CNT_W-1:0] active_r;

    // Software side holding value
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            buf_o <= MATCH_RST;
        end else if (wr_i) begin
            buf_o <= wdata_i;
        end
    end

    // Active value moves only on a permitted load
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            active_r <= MATCH_RST;
        end else if (load_i) begin
            active_r <= buf_o;
        end
    end

    // Compare output
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwm_o <= 1'b0;
        end else begin
            pwm_o <= (cnt_i < active_r);
        end
    end
endmodule
`default_nettype wire

// [rtl/pwm_timer_module.sv]
// What this block does
// - Buffer load control takes 8, 16 and 32-bit writes; narrow ones keep load permit unless they write byte lane 1.
// - Load permit set lets buffered limit, start and match values load; clear blocks.
// - Overflow flag clears by reading status while set, then writing zero.
// - Nonzero skip setting: count overflows, compare against setting before flagging.
// - Overflow interrupt high while flag and enable both set; drops with flag.
// - Skip setting zero: every overflow sets the flag.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_module (
    input wire logic clk_i,                                 // Module clock, 100 MHz
    input wire logic srst_i,                                // Sync reset, high
    input wire logic psel_i,                                // APB select
    input wire logic penable_i,                             // APB enable
    input wire logic pwrite_i,                              // APB direction
    input wire logic [pwm_timer_pkg::ADDR_W-1:0] paddr_i,   // APB byte address
    input wire logic [31:0] pwdata_i,                       // APB write data
    input wire logic [3:0] pstrb_i,                         // APB byte strobes
    output logic [31:0] prdata_o,                           // APB read data
    output logic pready_o,                                  // APB ready
    output logic pslverr_o,                                 // APB error, unmapped
    output logic [pwm_timer_pkg::NUM_CH-1:0] pwm_o,         // Channel compare outputs
    output logic overflow_irq_o,                            // Overflow interrupt level
    output logic irq_o                                      // Masked sticky interrupt
);
    import pwm_timer_pkg::*;

    logic run_en_r, ovf_ie_r, ovf_flag_r, clr_armed_r, load_permit_r;
    logic [CNT_W-1:0] limit_buf_r, limit_r, start_buf_r, start_r, cnt_r;
    logic [SKIP_W-1:0] skip_r, skip_cnt_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
    logic [CNT_W-1:0] match_buf [NUM_CH];
    logic [31:0] rd_nxt, wdat;
    logic hit, wr_acc, rd_acc, ovf_evt, load_evt, ovf_set, flag_clr;
    logic flag_nxt, ie_nxt;
    logic [IRQ_W-1:0] evt, irq_stat_nxt, irq_mask_nxt;

    // Byte lane merge so narrow writes touch only their lanes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                res[8*i+:8] = nw[8*i+:8];
            end
        end
        return res;
    endfunction

    // Access phase strobes; effects land on the edge that sees pready
    assign wr_acc = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_acc = psel_i & penable_i & pready_o & ~pwrite_i;
    assign wdat = merge(rd_nxt, pwdata_i, pstrb_i);

    // Read mux and address decode
    always_comb begin
        rd_nxt = '0;
        hit = 1'b1;
        if (paddr_i == OFS_STATUS_CONTROL) begin
            rd_nxt[CTL_EN_BIT] = run_en_r;
            rd_nxt[CTL_IE_BIT] = ovf_ie_r;
            rd_nxt[CTL_FLAG_BIT] = ovf_flag_r;
        end else if (paddr_i == OFS_COUNT_LIMIT) begin
            rd_nxt[CNT_W-1:0] = limit_buf_r;
        end else if (paddr_i == OFS_COUNTER_START) begin
            rd_nxt[CNT_W-1:0] = start_buf_r;
        end else if (paddr_i == OFS_COUNTER) begin
            rd_nxt[CNT_W-1:0] = cnt_r;
        end else if (paddr_i == OFS_SETUP) begin
            rd_nxt[SKIP_W-1:0] = skip_r;
        end else if (paddr_i == OFS_BUFFER_LOAD) begin
            rd_nxt[LOAD_PERMIT_BIT] = load_permit_r;
        end else if (paddr_i == OFS_MATCH0) begin
            rd_nxt[CNT_W-1:0] = match_buf[0];
        end else if (paddr_i == OFS_MATCH1) begin
            rd_nxt[CNT_W-1:0] = match_buf[1];
        end else if (paddr_i == OFS_IRQ_STATUS) begin
            rd_nxt[IRQ_W-1:0] = irq_stat_r;
        end else if (paddr_i == OFS_IRQ_MASK) begin
            rd_nxt[IRQ_W-1:0] = irq_mask_r;
        end else begin
            hit = 1'b0;
        end
    end

    // APB answer: one access cycle, data captured in setup
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o <= 1'b0;
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            if (psel_i & ~penable_i) begin
                prdata_o <= pwrite_i ? '0 : rd_nxt;
                pslverr_o <= ~hit;
            end else begin
                pslverr_o <= 1'b0;
            end
        end
    end

    // Counter and overflow events
    assign ovf_evt = run_en_r & (cnt_r == limit_r);
    assign load_evt = ovf_evt & load_permit_r;
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_r <= START_RST;
        end else if (ovf_evt) begin
            cnt_r <= load_evt ? start_buf_r : start_r;
        end else if (run_en_r) begin
            cnt_r <= CNT_W'(cnt_r + 1'h1);
        end
    end

    // Active limit and start value follow buffers only when permitted
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            limit_r <= LIMIT_RST;
            start_r <= START_RST;
        end else if (load_evt) begin
            limit_r <= limit_buf_r;
            start_r <= start_buf_r;
        end
    end

    // Software values: buffered limit and start, direct skip, mask and run enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            limit_buf_r <= LIMIT_RST;
            start_buf_r <= START_RST;
            skip_r <= SKIP_RST;
            irq_mask_r <= IRQ_RST;
            run_en_r <= 1'b0;
        end else if (wr_acc) begin
            if (paddr_i == OFS_COUNT_LIMIT) begin
                limit_buf_r <= wdat[CNT_W-1:0];
            end else if (paddr_i == OFS_COUNTER_START) begin
                start_buf_r <= wdat[CNT_W-1:0];
            end else if (paddr_i == OFS_SETUP) begin
                skip_r <= wdat[SKIP_W-1:0];
            end else if (paddr_i == OFS_IRQ_MASK) begin
                irq_mask_r <= wdat[IRQ_W-1:0];
            end else if (paddr_i == OFS_STATUS_CONTROL) begin
                run_en_r <= wdat[CTL_EN_BIT];
            end
        end
    end

    // Load permit: software sets or clears, a load clears it, write wins
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            load_permit_r <= 1'b0;
        end else if (wr_acc && paddr_i == OFS_BUFFER_LOAD) begin
            load_permit_r <= wdat[LOAD_PERMIT_BIT];
        end else if (load_evt) begin
            load_permit_r <= 1'b0;
        end
    end

    // Match channels
    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        pwm_match_channel u_ch (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .wr_i(wr_acc && paddr_i == (OFS_MATCH0 + ADDR_W'(4 * ch))),
            .wdata_i(wdat[CNT_W-1:0]),
            .load_i(load_evt),
            .cnt_i(cnt_r),
            .buf_o(match_buf[ch]),
            .pwm_o(pwm_o[ch])
        );
    end

    // Overflow skip counting; setting zero flags every overflow
    assign ovf_set = ovf_evt & ((skip_r == '0) ||
        ((SKIP_W + 1)'(skip_cnt_r) + (SKIP_W + 1)'(1) >= (SKIP_W + 1)'(skip_r)));
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            skip_cnt_r <= '0;
        end else if (ovf_set) begin
            skip_cnt_r <= '0;
        end else if (ovf_evt) begin
            skip_cnt_r <= SKIP_W'(skip_cnt_r + 1'h1);
        end
    end

    // Flag next state: a new overflow beats a clear
    assign flag_clr = wr_acc && paddr_i == OFS_STATUS_CONTROL && clr_armed_r
                      && !wdat[CTL_FLAG_BIT];
    always_comb begin
        flag_nxt = ovf_flag_r;
        ie_nxt = ovf_ie_r;
        if (ovf_set) begin
            flag_nxt = 1'b1;
        end else if (flag_clr) begin
            flag_nxt = 1'b0;
        end
        if (wr_acc && paddr_i == OFS_STATUS_CONTROL) begin
            ie_nxt = wdat[CTL_IE_BIT];
        end
    end

    // Flag, enable, and the clear arming by a read that saw the flag
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ovf_flag_r <= 1'b0;
            ovf_ie_r <= 1'b0;
            clr_armed_r <= 1'b0;
            overflow_irq_o <= 1'b0;
        end else begin
            ovf_flag_r <= flag_nxt;
            ovf_ie_r <= ie_nxt;
            overflow_irq_o <= flag_nxt & ie_nxt;
            if (rd_acc && paddr_i == OFS_STATUS_CONTROL) begin
                clr_armed_r <= prdata_o[CTL_FLAG_BIT];
            end else if (wr_acc && paddr_i == OFS_STATUS_CONTROL) begin
                clr_armed_r <= 1'b0;
            end
        end
    end

    // Sticky status, cleared by reading it; only bits shown are cleared
    assign evt = {load_evt, ovf_set};
    always_comb begin
        irq_stat_nxt = irq_stat_r | evt;
        irq_mask_nxt = irq_mask_r;
        if (rd_acc && paddr_i == OFS_IRQ_STATUS) begin
            irq_stat_nxt = (irq_stat_r & ~prdata_o[IRQ_W-1:0]) | evt;
        end
        if (wr_acc && paddr_i == OFS_IRQ_MASK) begin
            irq_mask_nxt = wdat[IRQ_W-1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_stat_r <= IRQ_RST;
            irq_o <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_o <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // Checks
    AST_NARROW_KEEP: assert property (@(posedge clk_i) disable iff (srst_i)
        (wr_acc && paddr_i == OFS_BUFFER_LOAD && !pstrb_i[1] && !load_evt)
        |=> load_permit_r == $past(load_permit_r))
        else $error("narrow write changed load permit");
    AST_BLOCKED: assert property (@(posedge clk_i) disable iff (srst_i)
        (ovf_evt && !load_permit_r) |=> $stable(limit_r) && $stable(start_r))
        else $error("active values moved without permit");
    AST_LOADED: assert property (@(posedge clk_i) disable iff (srst_i)
        load_evt |=> limit_r == $past(limit_buf_r) && start_r == $past(start_buf_r))
        else $error("permitted load did not copy buffers");
    AST_CLEAR_NEEDS_READ: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(ovf_flag_r) |-> $past(clr_armed_r) && $past(wr_acc))
        else $error("flag cleared without read then write");
    AST_SKIP: assert property (@(posedge clk_i) disable iff (srst_i)
        (ovf_evt && skip_r > SKIP_W'(1) && !ovf_flag_r &&
         (SKIP_W + 1)'(skip_cnt_r) + (SKIP_W + 1)'(1) < (SKIP_W + 1)'(skip_r))
        |=> !ovf_flag_r)
        else $error("flag set before skip count reached");
    AST_EVERY: assert property (@(posedge clk_i) disable iff (srst_i)
        (ovf_evt && skip_r == '0) |=> ovf_flag_r ##1 1'b1)
        else $error("overflow with zero skip did not flag");
    AST_IRQ_LEVEL: assert property (@(posedge clk_i) disable iff (srst_i)
        overflow_irq_o == (ovf_flag_r && ovf_ie_r))
        else $error("overflow interrupt disagrees with flag and enable");
    AST_WRAP: assert property (@(posedge clk_i) disable iff (srst_i)
        (ovf_evt && !load_evt) |=> cnt_r == $past(start_r))
        else $error("counter did not reload start value");
    AST_COUNT: assert property (@(posedge clk_i) disable iff (srst_i)
        (run_en_r && cnt_r != limit_r) |=> cnt_r == CNT_W'($past(cnt_r) + 1'h1))
        else $error("counter did not advance");
endmodule
`default_nettype wire

// [dv/test_timer_overflow_and_buffer_load.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_timer_overflow_and_buffer_load;
    import pwm_timer_pkg::*;
    typedef struct packed {logic err; logic [31:0] d; logic [31:0] m;} exp_t;
    logic clk_i, srst_i, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, rdat;
    logic [3:0] pstrb;
    logic [15:0] lfsr_r;
    logic [3:0] stb [4] = '{4'b0001, 4'b1100, 4'b0100, 4'b1000};
    wire logic [31:0] prdata;
    wire logic pready, pslverr, ovf_irq, irq;
    wire logic [NUM_CH-1:0] pwm;
    exp_t exp_q [$];
    exp_t cur;
    int fail_count, total_checks;
    int cyc = 0;

    pwm_timer_module i_dut (
        .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .pwm_o(pwm),
        .overflow_irq_o(ovf_irq), .irq_o(irq)
    );

    // Clock and cycle count
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= cyc + 1;

    // Pseudo-random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Read monitor, oldest expectation first
    always @(posedge clk_i) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                `CHK("read queue", 1'b1, 1'b0)
            end else begin
                cur = exp_q.pop_front();
                `CHK("prdata", cur.d & cur.m, prdata & cur.m)
                `CHK("pslverr", cur.err, pslverr)
            end
        end
    end

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task timeout(input string nm);
        fail_count++;
        $display("mismatch %s expected done seen timeout", nm);
        print_verdict;
    endtask

    // One APB transfer, held until pready
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
             input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1) begin
            if (++n > 20) timeout("pready");
            @(posedge clk_i);
        end
        rdat = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask

    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask

    task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m,
            input logic err);
        exp_q.push_back('{err, e, m});
        apb(1'b0, a, 32'h0000_0000, 4'hf);
    endtask

    task wait_ovf(input int lim, output int n);
        n = 0;
        while (ovf_irq !== 1'b1) begin
            @(posedge clk_i);
            if (++n > lim) timeout("overflow irq");
        end
    endtask

    task settle;
        repeat (2) @(posedge clk_i);
    endtask

    // Read, then write zero to the flag, until it reads clear
    task clear_flag(input logic [31:0] wv);
        int k;
        k = 0;
        rd(OFS_STATUS_CONTROL, 32'h0000_0000, 32'h0000_0000, 1'b0);
        while (rdat[CTL_FLAG_BIT] !== 1'b0) begin
            if (++k > 8) timeout("flag clear");
            wr(OFS_STATUS_CONTROL, wv, 4'hf);
            rd(OFS_STATUS_CONTROL, 32'h0000_0000, 32'h0000_0000, 1'b0);
        end
    endtask

    // Main sequence
    initial begin
        int n, ta, tb;
        logic [15:0] mx;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
        pwdata = '0; pstrb = '0; srst_i = 1'b1;
        fail_count = 0; total_checks = 0; lfsr_r = 16'h0010;
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("overflow_irq_o", 1'b0, ovf_irq)
        `CHK("pwm_o", 2'b00, pwm)
        rd(OFS_STATUS_CONTROL, 32'h0000_0000, 32'hffff_ffff, 1'b0);
        rd(OFS_COUNT_LIMIT, 32'h0000_ffff, 32'hffff_ffff, 1'b0);
        rd(8'h40, 32'h0000_0000, 32'hffff_ffff, 1'b1);
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(i[0] ? OFS_MATCH1 : OFS_MATCH0, {16'h0000, lfsr_r}, 4'hf);
            rd(i[0] ? OFS_MATCH1 : OFS_MATCH0, {16'h0000, lfsr_r}, 32'h0000_ffff, 1'b0);
        end
        // Narrow writes keep the load permit unless they write byte lane 1
        wr(OFS_BUFFER_LOAD, 32'h0000_0200, 4'hf);
        rd(OFS_BUFFER_LOAD, 32'h0000_0200, 32'hffff_ffff, 1'b0);
        for (int i = 0; i < 4; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            wr(OFS_BUFFER_LOAD, {lfsr_r, lfsr_r} & 32'hffff_fdff, stb[i]);
            rd(OFS_BUFFER_LOAD, 32'h0000_0200, 32'h0000_0200, 1'b0);
        end
        wr(OFS_BUFFER_LOAD, 32'h0000_0200, 4'b0011);
        rd(OFS_BUFFER_LOAD, 32'h0000_0200, 32'h0000_0200, 1'b0);
        wr(OFS_BUFFER_LOAD, 32'h0000_0000, 4'b0010);
        rd(OFS_BUFFER_LOAD, 32'h0000_0000, 32'h0000_0200, 1'b0);
        wr(OFS_BUFFER_LOAD, 32'h0000_0200, 4'hf);
        // Program buffers and run to the first overflow
        wr(OFS_COUNT_LIMIT, 32'h0000_0007, 4'hf);
        wr(OFS_COUNTER_START, 32'h0000_0002, 4'hf);
        wr(OFS_IRQ_MASK, 32'h0000_0003, 4'hf);
        wr(OFS_STATUS_CONTROL, 32'h0000_0041, 4'hf);
        wait_ovf(70000, n);
        wr(OFS_STATUS_CONTROL, 32'h0000_0040, 4'hf);
        settle;
        rd(OFS_BUFFER_LOAD, 32'h0000_0000, 32'h0000_0200, 1'b0);
        // Loaded match values lie above the stopped counter
        `CHK("pwm_o", 2'b11, pwm)
        // Interrupt mask and read-clear status
        `CHK("irq_o", 1'b1, irq)
        wr(OFS_IRQ_MASK, 32'h0000_0000, 4'hf);
        settle;
        `CHK("irq_o", 1'b0, irq)
        wr(OFS_IRQ_MASK, 32'h0000_0003, 4'hf);
        settle;
        `CHK("irq_o", 1'b1, irq)
        rd(OFS_IRQ_STATUS, 32'h0000_0003, 32'h0000_0003, 1'b0);
        settle;
        `CHK("irq_o", 1'b0, irq)
        rd(OFS_IRQ_STATUS, 32'h0000_0000, 32'h0000_0003, 1'b0);
        // Flag clear needs read first; irq follows flag and enable
        `CHK("overflow_irq_o", 1'b1, ovf_irq)
        wr(OFS_STATUS_CONTROL, 32'h0000_0000, 4'hf);
        settle;
        `CHK("overflow_irq_o", 1'b0, ovf_irq)
        rd(OFS_STATUS_CONTROL, 32'h0000_0080, 32'h0000_00c1, 1'b0);
        wr(OFS_STATUS_CONTROL, 32'h0000_0040, 4'hf);
        settle;
        `CHK("overflow_irq_o", 1'b0, ovf_irq)
        rd(OFS_STATUS_CONTROL, 32'h0000_0040, 32'h0000_00c1, 1'b0);
        // Limit update blocked without load permit
        wr(OFS_COUNT_LIMIT, 32'h0000_0003, 4'hf);
        wr(OFS_MATCH0, 32'h0000_0000, 4'hf);
        wr(OFS_STATUS_CONTROL, 32'h0000_0041, 4'hf);
        mx = '0;
        for (int i = 0; i < 8; i++) begin
            repeat (i) @(posedge clk_i);
            rd(OFS_COUNTER, 32'h0000_0000, 32'h0000_0000, 1'b0);
            `CHK("counter range", 1'b1, rdat >= 32'd2 && rdat <= 32'd7)
            if (rdat[15:0] > mx) mx = rdat[15:0];
        end
        `CHK("counter max", 1'b1, mx > 16'd3)
        `CHK("pwm_o", 2'b11, pwm)
        rd(OFS_COUNT_LIMIT, 32'h0000_0003, 32'h0000_ffff, 1'b0);
        wr(OFS_COUNT_LIMIT, 32'h0000_0007, 4'hf);
        // Skip zero: flag on every overflow
        wr(OFS_STATUS_CONTROL, 32'h0000_0040, 4'hf);
        clear_flag(32'h0000_0040);
        wr(OFS_STATUS_CONTROL, 32'h0000_0041, 4'hf);
        wait_ovf(40, n);
        `CHK("first flag delay", 1'b1, n <= 8)
        // Skip three: flag every third overflow
        wr(OFS_SETUP, 32'h0000_0003, 4'hf);
        rd(OFS_SETUP, 32'h0000_0003, 32'h0000_001f, 1'b0);
        wr(OFS_STATUS_CONTROL, 32'h0000_0040, 4'hf);
        clear_flag(32'h0000_0040);
        wr(OFS_STATUS_CONTROL, 32'h0000_0041, 4'hf);
        wait_ovf(100, n);
        ta = cyc;
        clear_flag(32'h0000_0041);
        wait_ovf(100, n);
        tb = cyc;
        `CHK("flag interval", 3 * (7 - 2 + 1), tb - ta)
        print_verdict;
    end
endmodule
`default_nettype wire
